// *** verilog/table_read_unit.sv ***
// execution of the paged table read, prescaler read and serial register read
// How it works
// - a table read bumps the stack pointer and, in the same cycle, pushes the program counter at the new level.
// - the counter page part takes the bank bit over the page operand and the low part takes index_register_d[2:0] over A[3:0].
// - the ROM word at that address goes out as B from bits 7..4 and A from bits 3..0.
// - the counter is then reloaded from the current stack level and the stack pointer stepped back.
// - while the table read runs it holds one level of the return stack.
// - the prescaler read puts prescaler bits 7..4 into B and bits 3..0 into A.
// - the serial register read puts serial bits 7..4 into B.
// - the serial register read puts serial bits 3..0 into A.
`timescale 1ns/1ps
`default_nettype none
module table_read_unit
  import tab_ops_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // decoded instruction strobes
  input wire logic paged_table_read_op_i,
  input wire logic [PAGE_OP_W-1:0] page_operand_i,
  input wire logic prescaler_read_op_i,
  input wire logic serial_shift_read_op_i,
  input wire logic bank_set_op_i,
  input wire logic bank_reset_op_i,
  // core state
  input wire logic [PC_W-1:0] program_counter_i,
  input wire logic [D_W-1:0] index_register_d_i,
  input wire logic [NIB_W-1:0] acc_i,
  // sources
  input wire logic [ROM_W-1:0] rom_data_i,
  input wire logic [BYTE_W-1:0] prescaler_value_i,
  input wire logic [BYTE_W-1:0] serial_shift_i,
  // results
  output logic [PC_W-1:0] program_counter_o,
  output logic pc_load_o,
  output logic rom_rd_o,
  output logic [NIB_W-1:0] reg_b_o,
  output logic [NIB_W-1:0] reg_a_o,
  output logic ba_load_o,
  output logic busy_o,
  output logic [SP_W-1:0] stack_pointer_o,
  output logic bank_o
);
  tab_state_t state_q;
  logic [SP_W-1:0] stack_pointer_q;
  logic [SP_W-1:0] entry_sp_q;
  logic bank_q;
  logic [PC_W-1:0] stack_rdata;
  logic take_table;
  logic take_presc;
  logic take_serial;
  logic stack_we;
  logic [SP_W-1:0] stack_waddr;
  logic stack_re;

  function automatic logic [NIB_W-1:0] hi_nib(input logic [BYTE_W-1:0] v);
    return v[HI_MSB:HI_LSB];
  endfunction : hi_nib

  function automatic logic [NIB_W-1:0] lo_nib(input logic [BYTE_W-1:0] v);
    return v[LO_MSB:LO_LSB];
  endfunction : lo_nib

  // table, prescaler and serial reads are only taken while idle (bank set/reset in any state); the core does not issue during a table read
  assign take_table = ce_i && state_q == ST_IDLE && paged_table_read_op_i;
  assign take_presc = ce_i && state_q == ST_IDLE && !paged_table_read_op_i && prescaler_read_op_i;
  assign take_serial = ce_i && state_q == ST_IDLE && !paged_table_read_op_i && !prescaler_read_op_i
                       && serial_shift_read_op_i;

  // push at the incremented level, pop from the current level
  assign stack_we = take_table;
  assign stack_waddr = SP_W'(stack_pointer_q + 1'b1);
  assign stack_re = state_q == ST_FETCH;

  return_stack_mem u_stack (
    .mclk_i(mclk_i),
    .ce_i(ce_i),
    .we_i(stack_we),
    .waddr_i(stack_waddr),
    .wdata_i(program_counter_i),
    .re_i(stack_re),
    .raddr_i(stack_pointer_q),
    .rdata_o(stack_rdata)
  );

  // sequencer
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= ST_IDLE;
    end else if (ce_i) begin
      case (state_q)
        ST_IDLE: begin
          if (paged_table_read_op_i) begin
            state_q <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          state_q <= ST_RESTORE;
        end
        ST_RESTORE: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // stack pointer: up on entry, down in the same cycle the counter is restored
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stack_pointer_q <= SP_RESET;
      entry_sp_q <= SP_RESET;
    end else if (take_table) begin
      stack_pointer_q <= SP_W'(stack_pointer_q + 1'b1);
      entry_sp_q <= stack_pointer_q;
    end else if (ce_i && state_q == ST_RESTORE) begin
      stack_pointer_q <= SP_W'(stack_pointer_q - 1'b1);
    end
  end

  // bank select for the page operand; set wins if both arrive together
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bank_q <= BANK_RESET;
    end else if (ce_i && bank_set_op_i) begin
      bank_q <= 1'b1;
    end else if (ce_i && bank_reset_op_i) begin
      bank_q <= 1'b0;
    end
  end

  // program counter loads: table address on entry, saved counter on exit
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      program_counter_o <= PC_RESET;
      pc_load_o <= 1'b0;
      rom_rd_o <= 1'b0;
    end else if (ce_i) begin
      pc_load_o <= 1'b0;
      rom_rd_o <= 1'b0;
      if (take_table) begin
        program_counter_o <= {bank_q, page_operand_i, index_register_d_i, acc_i};
        pc_load_o <= 1'b1;
        rom_rd_o <= 1'b1;
      end else if (state_q == ST_RESTORE) begin
        program_counter_o <= stack_rdata;
        pc_load_o <= 1'b1;
      end
    end
  end

  // B and A loads; carry and skip are never driven from here
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_b_o <= NIB_RESET;
      reg_a_o <= NIB_RESET;
      ba_load_o <= 1'b0;
    end else if (ce_i) begin
      ba_load_o <= 1'b0;
      if (state_q == ST_FETCH) begin
        reg_b_o <= hi_nib(rom_data_i[BYTE_W-1:0]);
        reg_a_o <= lo_nib(rom_data_i[BYTE_W-1:0]);
        ba_load_o <= 1'b1;
      end else if (take_presc) begin
        reg_b_o <= hi_nib(prescaler_value_i);
        reg_a_o <= lo_nib(prescaler_value_i);
        ba_load_o <= 1'b1;
      end else if (take_serial) begin
        reg_b_o <= hi_nib(serial_shift_i);
        reg_a_o <= lo_nib(serial_shift_i);
        ba_load_o <= 1'b1;
      end
    end
  end

  // status outputs are registered from the next-state values so they track internal state with no lag
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_o <= 1'b0;
      stack_pointer_o <= SP_RESET;
      bank_o <= BANK_RESET;
    end else if (ce_i) begin
      busy_o <= take_table || state_q == ST_FETCH;
      stack_pointer_o <= take_table ? SP_W'(stack_pointer_q + 1'b1)
                       : (state_q == ST_RESTORE ? SP_W'(stack_pointer_q - 1'b1) : stack_pointer_q);
      bank_o <= bank_set_op_i ? 1'b1 : (bank_reset_op_i ? 1'b0 : bank_q);
    end
  end

  push_order_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    take_table |-> stack_we && stack_waddr == SP_W'(stack_pointer_q + 1'b1)
      ##1 stack_pointer_q == SP_W'($past(stack_pointer_q) + 1'b1))
    else $error("push level differs from new stack pointer");

  page_address_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    take_table |=> pc_load_o && rom_rd_o
      && program_counter_o == {$past(bank_q), $past(page_operand_i), $past(index_register_d_i), $past(acc_i)})
    else $error("table address not formed from page, D and A");

  rom_nibbles_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (ce_i && state_q == ST_FETCH) |=> ba_load_o && reg_b_o == $past(rom_data_i[HI_MSB:HI_LSB])
      && reg_a_o == $past(rom_data_i[LO_MSB:LO_LSB]))
    else $error("ROM word not split into B and A");

  pc_restore_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (ce_i && state_q == ST_RESTORE) |=> pc_load_o && program_counter_o == $past(stack_rdata)
      && stack_pointer_q == SP_W'($past(stack_pointer_q) - 1'b1))
    else $error("counter not restored or stack not popped");

  one_level_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    state_q != ST_IDLE |-> stack_pointer_q == SP_W'(entry_sp_q + 1'b1))
    else $error("table read holds other than one stack level");

  presc_read_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    take_presc |=> ba_load_o && {reg_b_o, reg_a_o} == $past(prescaler_value_i))
    else $error("prescaler nibbles misplaced");

  serial_high_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    take_serial |=> ba_load_o && reg_b_o == $past(serial_shift_i[HI_MSB:HI_LSB]))
    else $error("serial high nibble not in B");

  serial_low_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    take_serial |=> reg_a_o == $past(serial_shift_i[LO_MSB:LO_LSB]))
    else $error("serial low nibble not in A");

  bank_track_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (ce_i && bank_set_op_i) |=> bank_q ##0 bank_o)
    else $error("bank set not taken");

  three_cycles_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (take_table ##1 ce_i ##1 ce_i) |=> state_q == ST_IDLE && pc_load_o && !busy_o)
    else $error("table read not three cycles");
endmodule : table_read_unit
`default_nettype wire

// *** verilog/tab_ops_pkg.sv ***
// shared widths, reset values and cycle counts for the table and register read ops
package tab_ops_pkg;
  localparam int NIB_W = 4;
  localparam int BYTE_W = 8;
  localparam int ROM_W = 10;
  localparam int PAGE_OP_W = 6;
  localparam int PAGE_W = 7;
  localparam int LOW_W = 7;
  localparam int PC_W = PAGE_W + LOW_W;
  localparam int D_W = 3;
  localparam int SP_W = 3;
  localparam int STACK_DEPTH = 8;
  // hi nibble and lo nibble positions inside a byte
  localparam int HI_MSB = 7;
  localparam int HI_LSB = 4;
  localparam int LO_MSB = 3;
  localparam int LO_LSB = 0;
  // reset values
  localparam logic [SP_W-1:0] SP_RESET = 3'h7;
  localparam logic BANK_RESET = 1'b0;
  localparam logic [NIB_W-1:0] NIB_RESET = 4'h0;
  localparam logic [PC_W-1:0] PC_RESET = 14'h0000;
  // cycle counts
  localparam int TABLE_CYCLES = 3;
  localparam int REG_READ_CYCLES = 1;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_RESTORE = 2'b11
  } tab_state_t;
endpackage : tab_ops_pkg

// *** verilog/return_stack_mem.sv ***
// return stack storage with registered read data
`timescale 1ns/1ps
`default_nettype none
module return_stack_mem
  import tab_ops_pkg::*;
(
  // clock
  input wire logic mclk_i,
  input wire logic ce_i,
  // write port
  input wire logic we_i,
  input wire logic [SP_W-1:0] waddr_i,
  input wire logic [PC_W-1:0] wdata_i,
  // read port
  input wire logic re_i,
  input wire logic [SP_W-1:0] raddr_i,
  output logic [PC_W-1:0] rdata_o
);
  logic [PC_W-1:0] mem_q [STACK_DEPTH];

  // no reset on the storage: contents are only read after a push
  always_ff @(posedge mclk_i) begin
    if (ce_i && we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (ce_i && re_i) begin
      rdata_o <= mem_q[raddr_i];
    end
  end
endmodule : return_stack_mem
`default_nettype wire

// *** dv/tb.sv ***
// self-checking bench for the table and register read unit
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tab_ops_pkg::*;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic ce_i = 1'b1;
  logic tbl_op = 1'b0;
  logic psc_op = 1'b0;
  logic ser_op = 1'b0;
  logic bset = 1'b0;
  logic brst = 1'b0;
  logic [PAGE_OP_W-1:0] page_op = '0;
  logic [PC_W-1:0] pc_in = '0;
  logic [D_W-1:0] d_in = '0;
  logic [NIB_W-1:0] acc_in = '0;
  logic [ROM_W-1:0] rom_in = '0;
  logic [BYTE_W-1:0] psc_in = '0;
  logic [BYTE_W-1:0] ser_in = '0;
  logic [PC_W-1:0] pc_out;
  logic pc_load, rom_rd, ba_load, busy, bank;
  logic [NIB_W-1:0] b_out, a_out;
  logic [SP_W-1:0] sp_out;
  int num_errors = 0;
  int total_checks = 0;

  table_read_unit DUT (.mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(ce_i), .paged_table_read_op_i(tbl_op),
    .page_operand_i(page_op), .prescaler_read_op_i(psc_op), .serial_shift_read_op_i(ser_op),
    .bank_set_op_i(bset), .bank_reset_op_i(brst), .program_counter_i(pc_in), .index_register_d_i(d_in),
    .acc_i(acc_in), .rom_data_i(rom_in), .prescaler_value_i(psc_in), .serial_shift_i(ser_in),
    .program_counter_o(pc_out), .pc_load_o(pc_load), .rom_rd_o(rom_rd), .reg_b_o(b_out), .reg_a_o(a_out),
    .ba_load_o(ba_load), .busy_o(busy), .stack_pointer_o(sp_out), .bank_o(bank));

  always #2.5 mclk_i = ~mclk_i;

  task automatic chk(input string what, input logic [PC_W-1:0] exp, input logic [PC_W-1:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic report_and_stop;
    if (num_errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  // three-cycle table read with a refused serial strobe in the fetch cycle
  task automatic table_read(input logic [5:0] p, input logic [2:0] d, input logic [3:0] a,
                            input logic [7:0] rom, input logic bk);
    logic [PC_W-1:0] saved;
    saved = {p, d, a, 1'b1} ^ 14'h2A5A;
    tbl_op = 1'b1; page_op = p; d_in = d; acc_in = a; pc_in = saved;
    @(negedge mclk_i);
    tbl_op = 1'b0;
    ser_op = 1'b1;
    ser_in = 8'hC3;
    rom_in = {2'b11, rom};
    chk("table addr", {bk, p, d, a}, pc_out);
    chk("pc_load fetch", PC_W'(1), PC_W'(pc_load));
    chk("rom_rd", PC_W'(1), PC_W'(rom_rd));
    chk("busy fetch", PC_W'(1), PC_W'(busy));
    chk("sp pushed", PC_W'(0), PC_W'(sp_out));
    @(negedge mclk_i);
    ser_op = 1'b0;
    rom_in = ~rom_in;
    chk("table b", PC_W'(rom[7:4]), PC_W'(b_out));
    chk("table a", PC_W'(rom[3:0]), PC_W'(a_out));
    chk("ba_load table", PC_W'(1), PC_W'(ba_load));
    chk("sp held", PC_W'(0), PC_W'(sp_out));
    @(negedge mclk_i);
    chk("pc restored", saved, pc_out);
    chk("pc_load restore", PC_W'(1), PC_W'(pc_load));
    chk("sp popped", PC_W'(7), PC_W'(sp_out));
    chk("busy done", PC_W'(0), PC_W'(busy));
    chk("refused serial", PC_W'(0), PC_W'(ba_load));
    chk("b kept", PC_W'(rom[7:4]), PC_W'(b_out));
  endtask : table_read

  // prescaler and serial strobe together, then serial alone back to back
  task automatic reg_reads(input logic [7:0] pv, input logic [7:0] sv);
    psc_in = pv; ser_in = sv; psc_op = 1'b1; ser_op = 1'b1;
    @(negedge mclk_i);
    psc_op = 1'b0;
    psc_in = ~pv;
    chk("psc b", PC_W'(pv[7:4]), PC_W'(b_out));
    chk("psc a", PC_W'(pv[3:0]), PC_W'(a_out));
    chk("ba_load psc", PC_W'(1), PC_W'(ba_load));
    @(negedge mclk_i);
    ser_op = 1'b0;
    ser_in = ~sv;
    chk("ser b", PC_W'(sv[7:4]), PC_W'(b_out));
    chk("ser a", PC_W'(sv[3:0]), PC_W'(a_out));
    chk("ba_load ser", PC_W'(1), PC_W'(ba_load));
    chk("no pc load", PC_W'(0), PC_W'(pc_load));
    @(negedge mclk_i);
    chk("ba_load drop", PC_W'(0), PC_W'(ba_load));
  endtask : reg_reads

  // bank pulses with set winning over reset
  task automatic bank_pulse(input logic s, input logic r, input logic exp);
    bset = s; brst = r;
    @(negedge mclk_i);
    bset = 1'b0; brst = 1'b0;
    chk("bank", PC_W'(exp), PC_W'(bank));
  endtask : bank_pulse

  // clock enable low in mid table read: nothing moves, a strobe is not taken, then the read finishes
  task automatic freeze_read(input logic [7:0] rom);
    logic [NIB_W-1:0] b_before;
    b_before = b_out;
    tbl_op = 1'b1; page_op = 6'h2C; d_in = 3'h1; acc_in = 4'h3; pc_in = 14'h1234;
    @(negedge mclk_i);
    tbl_op = 1'b0;
    ce_i = 1'b0;
    psc_op = 1'b1;
    psc_in = 8'h5A;
    rom_in = {2'b00, ~rom};
    repeat (2) @(negedge mclk_i);
    chk("frozen addr", {1'b0, 6'h2C, 3'h1, 4'h3}, pc_out);
    chk("frozen busy", PC_W'(1), PC_W'(busy));
    chk("frozen b", PC_W'(b_before), PC_W'(b_out));
    chk("frozen sp", PC_W'(0), PC_W'(sp_out));
    ce_i = 1'b1;
    psc_op = 1'b0;
    rom_in = {2'b00, rom};
    @(negedge mclk_i);
    chk("thawed b", PC_W'(rom[7:4]), PC_W'(b_out));
    chk("thawed a", PC_W'(rom[3:0]), PC_W'(a_out));
    @(negedge mclk_i);
    chk("thawed pc", 14'h1234, pc_out);
    chk("thawed sp", PC_W'(7), PC_W'(sp_out));
    chk("thawed busy", PC_W'(0), PC_W'(busy));
  endtask : freeze_read

  // reset in the fetch cycle of a table read returns the unit to idle
  task automatic reset_mid_read;
    tbl_op = 1'b1; page_op = 6'h01; pc_in = 14'h0ABC;
    @(negedge mclk_i);
    tbl_op = 1'b0;
    nrst_i = 1'b0;
    @(negedge mclk_i);
    chk("rst busy", PC_W'(0), PC_W'(busy));
    chk("rst sp", PC_W'(SP_RESET), PC_W'(sp_out));
    chk("rst pc_load", PC_W'(0), PC_W'(pc_load));
    chk("rst bank", PC_W'(0), PC_W'(bank));
    nrst_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    chk("idle busy", PC_W'(0), PC_W'(busy));
    chk("idle sp", PC_W'(SP_RESET), PC_W'(sp_out));
    chk("idle ba_load", PC_W'(0), PC_W'(ba_load));
  endtask : reset_mid_read

  initial begin
    repeat (5) @(negedge mclk_i);
    nrst_i = 1'b1;
    chk("sp reset", PC_W'(SP_RESET), PC_W'(sp_out));
    chk("bank reset", PC_W'(0), PC_W'(bank));
    table_read(6'h3F, 3'h5, 4'hA, 8'h96, 1'b0);
    table_read(6'h00, 3'h0, 4'h0, 8'h0F, 1'b0);
    reg_reads(8'hA5, 8'h3C);
    bank_pulse(1'b1, 1'b0, 1'b1);
    table_read(6'h15, 3'h7, 4'hF, 8'hF0, 1'b1);
    bank_pulse(1'b0, 1'b1, 1'b0);
    bank_pulse(1'b1, 1'b1, 1'b1);
    table_read(6'h2A, 3'h2, 4'h6, 8'h5A, 1'b1);
    bank_pulse(1'b0, 1'b1, 1'b0);
    reg_reads(8'h0F, 8'hF0);
    freeze_read(8'h69);
    reset_mid_read();
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
